// *** design/apll_defines.svh ***
// Purpose: Offsets, field positions and reset values of the analog PLL control bank
// Assumes: Byte-wide register access at the printed offsets
// Notes:   Included by bare name; definitions only
`ifndef APLL_DEFINES_SVH
`define APLL_DEFINES_SVH

`define APLL_ADDR_W          8
`define APLL_OFS_FILTER      8'h68
`define APLL_OFS_MODE        8'h69
`define APLL_OFS_MANUAL      8'h6A
`define APLL_OFS_SPARE       8'h6B

// Field positions in the filter register
`define APLL_CPUMP_MSB       7
`define APLL_CPUMP_LSB       5
`define APLL_RSER_MSB        4
`define APLL_RSER_LSB        3
`define APLL_CPAR_MSB        2
`define APLL_CPAR_LSB        1
`define APLL_POLE_BIT        0
// Field positions in the mode register
`define APLL_TDC_BIT         4
`define APLL_SYN_BIT         3
`define APLL_LCW_BIT         1
`define APLL_OVR_BIT         0
// Field positions in the manual register
`define APLL_VCO_MSB         7
`define APLL_VCO_LSB         5
`define APLL_DLC_MSB         4
`define APLL_DLC_LSB         0

// Field reset values
`define APLL_RST_CPUMP       3'h4
`define APLL_RST_RSER        2'h1
`define APLL_RST_CPAR        2'h1
`define APLL_RST_POLE        1'h1
`define APLL_RST_TDC         1'h0
`define APLL_RST_SYN         1'h0
`define APLL_RST_LCW         1'h1
`define APLL_RST_OVR         1'h0
`define APLL_RST_VCO         3'h1
`define APLL_RST_DLC         5'h0B
`define APLL_RST_SPARE       8'h00

`endif

// *** design/apll_pkg.sv ***
// Purpose: Types shared by the analog PLL control bank
// Assumes: Nothing beyond the defines header
// Notes:   Types only; constants live in apll_defines.svh
package apll_pkg;
   typedef logic [7:0] apll_byte_t;
   typedef enum logic {
      APLL_LOCK_AUTO,
      APLL_LOCK_MANUAL
   } apll_lock_mode_e;
endpackage

// *** design/apll_ctrl_regs.sv ***
// Purpose: Analog PLL control register bank, four byte registers at 0x68..0x6B
// Assumes: Byte register port synchronous to i_clk_sys; writes take one cycle
// Notes:   Reserved bits are not stored and read back as zero
`timescale 1ns/10ps
`default_nettype none
`include "apll_defines.svh"

module apll_ctrl_regs (
   input  wire logic                        i_clk_sys,
   input  wire logic                        i_rst_b,
   input  wire logic                        i_clk_en,
   input  wire logic [`APLL_ADDR_W-1:0]     i_addr,
   input  wire logic                        i_wr_en,
   input  wire logic                        i_rd_en,
   input  wire logic [7:0]                  i_wr_data,
   output logic      [7:0]                  o_rd_data,
   output logic                             o_rd_valid,
   output logic      [2:0]                  o_charge_pump_current,
   output logic      [1:0]                  o_filter_series_resistor,
   output logic      [1:0]                  o_filter_parallel_capacitor,
   output logic                             o_second_pole_select,
   output logic                             o_time_to_digital_disable,
   output logic                             o_crystal_only_synthesis,
   output logic                             o_lock_counter_width,
   output logic                             o_lock_manual_override,
   output logic      [2:0]                  o_manual_oscillator_select,
   output logic      [4:0]                  o_manual_lock_code
);

   // Register map, one byte each; reserved bits are neither stored nor driven
   //   0x68  [7:5] charge pump code    [4:3] series resistor
   //         [2:1] parallel capacitor  [0]   second pole select
   //   0x69  [4]   converter disable   [3]   crystal-only synthesis
   //         [1]   lock counter width  [0]   lock manual override
   //         [7:5] and [2] reserved, dropped on write, read as zero
   //   0x6A  [7:5] oscillator select   [4:0] manual lock code
   //   0x6B  spare, writes dropped, reads zero
   // Any other address reads zero and ignores writes, so a stray access
   // outside the bank can never disturb the loop filter settings.
   // A read in the same cycle as a write returns the byte as it stood
   // before the write, which keeps read-modify-write by software coherent.
   // Reserved oscillator codes are kept as written; keeping out of them is
   // the software's duty, and filtering them here would hide a broken setup.
   // Field outputs change on the same enabled edge that takes the write.

   // Assemble a register image from stored fields; used by the read path
   // Kept in one place so the byte layout of a read matches the write decode
   function automatic apll_pkg::apll_byte_t read_mux(
      input logic [7:0] addr,
      input logic [2:0] cp,
      input logic [1:0] rs,
      input logic [1:0] cap,
      input logic       pole,
      input logic       tdc,
      input logic       syn,
      input logic       lcw,
      input logic       ovr,
      input logic [2:0] vco,
      input logic [4:0] dlc
   );
      apll_pkg::apll_byte_t v;
      v = 8'h00;
      case (addr)
         `APLL_OFS_FILTER: begin
            v = {cp, rs, cap, pole};
         end
         `APLL_OFS_MODE: begin
            v = {3'h0, tdc, syn, 1'h0, lcw, ovr};
         end
         `APLL_OFS_MANUAL: begin
            v = {vco, dlc};
         end
         default: begin
            v = `APLL_RST_SPARE; // Spare and unmapped bytes read zero
         end
      endcase
      return v;
   endfunction

   // Filter byte fields
   logic [2:0] cpump_ff;
   logic [2:0] nxt_cpump;
   logic [1:0] rser_ff;
   logic [1:0] nxt_rser;
   logic [1:0] cpar_ff;
   logic [1:0] nxt_cpar;
   logic       pole_ff;
   logic       nxt_pole;
   // Mode byte fields
   logic       tdc_ff;
   logic       nxt_tdc;
   logic       syn_ff;
   logic       nxt_syn;
   logic       lcw_ff;
   logic       nxt_lcw;
   apll_pkg::apll_lock_mode_e ovr_ff;
   apll_pkg::apll_lock_mode_e nxt_ovr;
   // Manual byte fields
   logic [2:0] vco_ff;
   logic [2:0] nxt_vco;
   logic [4:0] dlc_ff;
   logic [4:0] nxt_dlc;
   // Read port state
   logic [7:0] rdat_ff;
   logic [7:0] nxt_rdat;
   logic       rval_ff;
   logic       nxt_rval;

   // Next-state for all fields; reserved write bits are dropped
   always_comb begin
      nxt_cpump = cpump_ff;
      nxt_rser  = rser_ff;
      nxt_cpar  = cpar_ff;
      nxt_pole  = pole_ff;
      nxt_tdc   = tdc_ff;
      nxt_syn   = syn_ff;
      nxt_lcw   = lcw_ff;
      nxt_ovr   = ovr_ff;
      nxt_vco   = vco_ff;
      nxt_dlc   = dlc_ff;
      if (i_wr_en) begin
         case (i_addr)
            `APLL_OFS_FILTER: begin
               // Every bit of the filter byte is a field
               nxt_cpump = i_wr_data[`APLL_CPUMP_MSB:`APLL_CPUMP_LSB];
               nxt_rser  = i_wr_data[`APLL_RSER_MSB:`APLL_RSER_LSB];
               nxt_cpar  = i_wr_data[`APLL_CPAR_MSB:`APLL_CPAR_LSB];
               nxt_pole  = i_wr_data[`APLL_POLE_BIT];
            end
            `APLL_OFS_MODE: begin
               // Reserved bits of the mode byte are simply not picked up
               nxt_tdc = i_wr_data[`APLL_TDC_BIT];
               nxt_syn = i_wr_data[`APLL_SYN_BIT];
               nxt_lcw = i_wr_data[`APLL_LCW_BIT];
               nxt_ovr = apll_pkg::apll_lock_mode_e'(i_wr_data[`APLL_OVR_BIT]);
            end
            `APLL_OFS_MANUAL: begin
               // Reserved VCO codes are stored as written; software keeps out of them
               nxt_vco = i_wr_data[`APLL_VCO_MSB:`APLL_VCO_LSB];
               nxt_dlc = i_wr_data[`APLL_DLC_MSB:`APLL_DLC_LSB];
            end
            default: begin
               nxt_vco = vco_ff; // Spare byte holds nothing
            end
         endcase
      end
   end

   // Register stage; clock enable freezes everything
   // Reset wins over a low clock enable so a stalled bank still comes up clean
   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_b) begin
         cpump_ff <= `APLL_RST_CPUMP;
         rser_ff  <= `APLL_RST_RSER;
         cpar_ff  <= `APLL_RST_CPAR;
         pole_ff  <= `APLL_RST_POLE;
         tdc_ff   <= `APLL_RST_TDC;
         syn_ff   <= `APLL_RST_SYN;
         lcw_ff   <= `APLL_RST_LCW;
         ovr_ff   <= apll_pkg::apll_lock_mode_e'(`APLL_RST_OVR);
         vco_ff   <= `APLL_RST_VCO;
         dlc_ff   <= `APLL_RST_DLC;
      end else if (i_clk_en) begin
         cpump_ff <= nxt_cpump;
         rser_ff  <= nxt_rser;
         cpar_ff  <= nxt_cpar;
         pole_ff  <= nxt_pole;
         tdc_ff   <= nxt_tdc;
         syn_ff   <= nxt_syn;
         lcw_ff   <= nxt_lcw;
         ovr_ff   <= nxt_ovr;
         vco_ff   <= nxt_vco;
         dlc_ff   <= nxt_dlc;
      end
   end

   // Read path; the image is taken from the flops before any same-cycle write
   always_comb begin
      nxt_rval = i_rd_en;
      nxt_rdat = read_mux(i_addr, cpump_ff, rser_ff, cpar_ff, pole_ff, tdc_ff,
                          syn_ff, lcw_ff, ovr_ff, vco_ff, dlc_ff);
   end

   // Read registers; a frozen clock holds the last answer on the port
   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_b) begin
         rdat_ff <= `APLL_RST_SPARE;
         rval_ff <= 1'b0;
      end else if (i_clk_en) begin
         rdat_ff <= nxt_rdat;
         rval_ff <= nxt_rval;
      end
   end

   // Field outputs come straight from their flops
   // No logic sits after the flops, so the analog side sees glitch-free levels
   // even while software rewrites a neighbouring field of the same byte
   assign o_charge_pump_current       = cpump_ff;
   assign o_filter_series_resistor    = rser_ff;
   assign o_filter_parallel_capacitor = cpar_ff;
   assign o_second_pole_select        = pole_ff;
   assign o_time_to_digital_disable   = tdc_ff;
   assign o_crystal_only_synthesis    = syn_ff;
   assign o_lock_counter_width        = lcw_ff;
   assign o_lock_manual_override      = ovr_ff;
   assign o_manual_oscillator_select  = vco_ff;
   assign o_manual_lock_code          = dlc_ff;
   assign o_rd_data                   = rdat_ff;
   assign o_rd_valid                  = rval_ff;

endmodule

`default_nettype wire

// *** tb/apll_ctrl_regs_asserts.sv ***
// Purpose: Port assertions for the analog PLL control bank
// Assumes: One enabled edge of latency for writes and reads
// Notes:   Field bytes are rebuilt so each check is one relation
`timescale 1ns/10ps
`default_nettype none
module apll_chk (
   input wire logic       i_clk_sys,
   input wire logic       i_rst_b,
   input wire logic       i_clk_en,
   input wire logic [7:0] i_addr,
   input wire logic       i_wr_en,
   input wire logic       i_rd_en,
   input wire logic [7:0] i_wr_data,
   input wire logic [7:0] o_rd_data,
   input wire logic       o_rd_valid,
   input wire logic [2:0] o_charge_pump_current,
   input wire logic [1:0] o_filter_series_resistor,
   input wire logic [1:0] o_filter_parallel_capacitor,
   input wire logic       o_second_pole_select,
   input wire logic       o_time_to_digital_disable,
   input wire logic       o_crystal_only_synthesis,
   input wire logic       o_lock_counter_width,
   input wire logic       o_lock_manual_override,
   input wire logic [2:0] o_manual_oscillator_select,
   input wire logic [4:0] o_manual_lock_code
);
   logic [7:0] f68, f69, f6a, exp_rd;
   logic       we;
   // Reserved bits read as zero, so the rebuilt bytes match a read
   assign f68 = {o_charge_pump_current, o_filter_series_resistor,
                 o_filter_parallel_capacitor, o_second_pole_select};
   assign f69 = {3'h0, o_time_to_digital_disable, o_crystal_only_synthesis, 1'h0,
                 o_lock_counter_width, o_lock_manual_override};
   assign f6a = {o_manual_oscillator_select, o_manual_lock_code};
   assign we = i_clk_en & i_wr_en;
   assign exp_rd = (i_addr == 8'h68) ? f68 : (i_addr == 8'h69) ? f69 :
                   (i_addr == 8'h6a) ? f6a : 8'h00;
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (!i_rst_b);
   wr_filter_a: assert property (we && i_addr == 8'h68 |=> f68 == $past(i_wr_data))
      else $error("filter byte write lost");
   wr_mode_a: assert property (we && i_addr == 8'h69 |=> f69 == ($past(i_wr_data) & 8'h1b))
      else $error("mode byte write lost");
   wr_manual_a: assert property (we && i_addr == 8'h6a |=> f6a == $past(i_wr_data))
      else $error("manual byte write lost");
   field_hold_a: assert property (!(we && i_addr inside {8'h68, 8'h69, 8'h6a})
      |=> $stable({f68, f69, f6a})) else $error("field changed without write");
   rd_valid_a: assert property (i_clk_en |=> o_rd_valid == $past(i_rd_en))
      else $error("read valid wrong");
   rd_data_a: assert property (i_clk_en && i_rd_en |=> o_rd_data == $past(exp_rd))
      else $error("read data wrong");
   en_freeze_a: assert property (!i_clk_en |=> $stable(o_rd_valid) && $stable(o_rd_data))
      else $error("read outputs moved while disabled");
   rst_dflt_a: assert property (disable iff (1'b0) !i_rst_b |=> f68 == 8'h8b
      && f69 == 8'h02 && f6a == 8'h2b && !o_rd_valid) else $error("reset defaults wrong");
   cover property (we && i_rd_en);
   cover property (we && i_addr == 8'h6a);
   cover property (!i_clk_en && i_rd_en);
   cover property (disable iff (1'b0) !i_rst_b && !i_clk_en);
endmodule
bind apll_ctrl_regs apll_chk u_chk (.*);
`default_nettype wire

// *** tb/tb_top.sv ***
// Purpose: Self-checking bench for the analog PLL control bank
// Assumes: Inputs change on falling edges; results read just after rising edges
// Notes:   Random traffic writes reserved bits and codes on purpose
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin err_count++; \
   $display("mismatch t=%0t got=%h exp=%h", $time, a, b); end end
module tb_top;
   logic i_clk_sys = 0, i_rst_b = 0, i_clk_en = 1, i_wr_en = 0, i_rd_en = 0;
   logic [7:0] i_addr = 8'h00, i_wr_data = 8'h00, o_rd_data, rdv, ra;
   logic o_rd_valid, o_second_pole_select, o_time_to_digital_disable, rv;
   logic o_crystal_only_synthesis, o_lock_counter_width, o_lock_manual_override;
   logic [2:0] o_charge_pump_current, o_manual_oscillator_select;
   logic [1:0] o_filter_series_resistor, o_filter_parallel_capacitor;
   logic [4:0] o_manual_lock_code;
   logic [7:0] mem [4];
   int err_count = 0, cmp_count = 0, cyc_n = 0;
   apll_ctrl_regs DUT (.*);
   initial begin
      forever #2 i_clk_sys = ~i_clk_sys;
   end
   // Watchdog well above the few hundred cycles the sequence needs
   always @(posedge i_clk_sys) begin
      cyc_n++;
      if (cyc_n == 3000) begin
         err_count++;
         give_verdict();
      end
   end
   task automatic give_verdict();
      if (err_count == 0 && cmp_count > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   // Only defined bits are stored; the spare byte keeps nothing
   function automatic logic [7:0] msk(input logic [7:0] a);
      msk = (a == 8'h69) ? 8'h1b : (a == 8'h68 || a == 8'h6a) ? 8'hff : 8'h00;
   endfunction
   // Well-behaved software: reserved bits zero, oscillator code 000 or 001
   function automatic logic [7:0] legal(input logic [7:0] a, d);
      legal = d & msk(a);
      if (a == 8'h6a) legal[7:6] = 2'b00;
   endfunction
   task automatic mreset();
      mem = '{{3'h4, 2'h1, 2'h1, 1'h1}, 8'h02, {3'h1, 5'h0b}, 8'h00};
      rv = 0;
      rdv = 8'h00;
   endtask
   task automatic chk();
      `CHK(o_rd_valid, rv)
      if (rv) `CHK(o_rd_data, rdv)
      `CHK(o_charge_pump_current, mem[0][7:5])
      `CHK(o_filter_series_resistor, mem[0][4:3])
      `CHK(o_filter_parallel_capacitor, mem[0][2:1])
      `CHK(o_second_pole_select, mem[0][0])
      `CHK(o_time_to_digital_disable, mem[1][4])
      `CHK(o_crystal_only_synthesis, mem[1][3])
      `CHK(o_lock_counter_width, mem[1][1])
      `CHK(o_lock_manual_override, mem[1][0])
      `CHK(o_manual_oscillator_select, mem[2][7:5])
      `CHK(o_manual_lock_code, mem[2][4:0])
   endtask
   // One port cycle; the model reads before it writes, as the port does
   task automatic cyc(input logic [7:0] a, d, input logic w, r, e);
      @(negedge i_clk_sys);
      i_addr = a;
      i_wr_data = d;
      i_wr_en = w;
      i_rd_en = r;
      i_clk_en = e;
      @(posedge i_clk_sys);
      #1;
      if (e) begin
         rv = r;
         if (r) rdv = (a[7:2] == 6'h1a) ? mem[a[1:0]] : 8'h00;
         if (w && a[7:2] == 6'h1a) mem[a[1:0]] = d & msk(a);
      end
      chk();
   endtask
   initial begin
      void'($urandom(32'h41c3_82de));
      mreset();
      repeat (16) @(negedge i_clk_sys);
      i_rst_b = 1;
      chk();
      // Reset values of the bank, the spare byte and unmapped neighbours
      for (int a = 8'h66; a < 8'h6e; a++) cyc(8'(a), 8'h00, 1'b0, 1'b1, 1'b1);
      // Write and read at one edge return the old byte, then the new one
      // Crystal-only synthesis; the free-run forcing lives in another bank
      cyc(8'h69, 8'h08, 1'b1, 1'b1, 1'b1);
      cyc(8'h69, 8'h00, 1'b0, 1'b1, 1'b1);
      // Back-to-back random traffic with clock-enable stalls
      repeat (400) cyc(8'h66 + 8'($urandom % 8), 8'($urandom), 1'($urandom),
                       1'($urandom), ($urandom % 5) != 0);
      // Second reset in mid-run restores every default
      @(negedge i_clk_sys);
      i_rst_b = 0;
      i_wr_en = 0;
      i_rd_en = 0;
      i_clk_en = 0; // Reset must win over a frozen clock
      @(negedge i_clk_sys);
      i_rst_b = 1;
      mreset();
      chk();
      repeat (40) begin
         ra = 8'h68 + 8'($urandom % 4);
         cyc(ra, legal(ra, 8'($urandom)), 1'($urandom), 1'b1, 1'b1);
      end
      give_verdict();
   end
endmodule
`default_nettype wire
